// [logic/crb_rx_filter.sv]
// CAN receive buffers with acceptance filters and masks behind an Avalon-MM slave
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`default_nettype none

module crb_rx_filter
	import crb_pkg::*;
(
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rst,
	// Avalon-MM slave
	input  wire logic [AW-1:0]   avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [DW-1:0]   avs_writedata,
	input  wire logic [DW/8-1:0] avs_byteenable,
	output logic      [DW-1:0]   avs_readdata,
	output logic                 avs_waitrequest,
	// Frames from the protocol engine
	input  wire crb_frame_t      rx_frame,
	input  wire logic            rx_frame_valid,
	// Buffer status
	output logic      [NBUF-1:0] buffer_full_flag
);

	crb_hdr_t        hdr_r [NBUF];
	crb_hdr_t        hdr_nxt [NBUF];
	crb_idr_t        flt_r [NFLT];
	crb_idr_t        flt_nxt [NFLT];
	crb_idr_t        msk_r [NBUF];
	crb_idr_t        msk_nxt [NBUF];
	logic [MW-1:0]   pend_data_r;
	logic [MW-1:0]   pend_data_nxt;
	logic            pend_buf_r;
	logic            pend_buf_nxt;
	logic [NBUF-1:0] full_r;
	logic [NBUF-1:0] full_nxt;
	logic            pend_r;
	logic            pend_nxt;
	crb_bus_t        st_r;
	crb_bus_t        st_nxt;
	logic            wait_r;
	logic            wait_nxt;
	logic [DW-1:0]   rdata_r;
	logic [DW-1:0]   rdata_nxt;
	logic [NFLT-1:0] match;
	logic            win_found;
	logic [1:0]      win_flt;
	logic            win_buf;
	logic            load;
	crb_dec_t        dec;
	logic            bus_wr;
	logic [RW-1:0]   wr16;
	logic [1:0]      be2;
	logic [1:0]      wsel;
	logic            is_dat;
	logic            mem_we_bus;
	logic            commit;
	logic [MW/8-1:0] bus_wbe;
	logic [MW-1:0]   mem_rdata;
	logic [RW-1:0]   rd_mux;

	// ==================================================================
	// Functions
	function automatic crb_dec_t reg_decode(input logic [AW-1:0] a);
		crb_dec_t d;
		d = '0;
		d.grp = a[GRP_HI:GRP_LO];
		if (a[1:0] == 2'h0 && d.grp == GRP_BUF)
		begin
			d.hit = 1'b1;
			d.idx = {1'b0, a[BIDX_POS]};
			d.sel = a[BSEL_HI:SEL_LO];
		end
		else if (a[1:0] == 2'h0 && d.grp != 2'h3 && a[FSEL_HI:SEL_LO] != SEL_HOLE[1:0])
		begin
			d.hit = (d.grp == GRP_FLT) || !a[BIDX_POS];
			d.idx = (d.grp == GRP_FLT) ? a[FIDX_HI:FIDX_LO] : {1'b0, a[MIDX_POS]};
			d.sel = {1'b0, a[FSEL_HI:SEL_LO]};
		end
		return d;
	endfunction

	function automatic logic [RW-1:0] be_merge(input logic [RW-1:0] o, input logic [RW-1:0] n,
		input logic [1:0] be);
		return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
	endfunction

	function automatic logic [RW-1:0] buf_read(input crb_hdr_t h, input logic [2:0] sel);
		logic [RW-1:0] r;
		r = '0;
		if (sel == SEL_STD)
		begin
			r[STD_HI:STD_LO] = h.std_identifier;
			r[SUB_POS]       = h.subst_remote;
			r[XF_POS]        = h.extended_frame_flag;
		end
		else if (sel == SEL_EXT)
			r[EXTH_HI:0] = h.ext_identifier[EXT_HI:EXT_SPL];
		else if (sel == SEL_LEN)
		begin
			r[RW-1:EXTL_LO] = h.ext_identifier[EXT_SPL-1:0];
			r[REM_POS]      = h.remote_request_flag;
			r[LEN_HI:0]     = h.length_code;
		end
		else if (sel == SEL_CTL)
		begin
			r[CREM_POS]   = h.remote_request_flag;
			r[HIT_HI:0]   = h.filter_hit;
		end
		return r;
	endfunction

	function automatic logic [RW-1:0] idr_read(input crb_idr_t d, input logic [2:0] sel);
		logic [RW-1:0] r;
		r = '0;
		if (sel == SEL_STD)
		begin
			r[STD_HI:STD_LO] = d.std_identifier;
			r[XF_POS]        = d.type_bit;
		end
		else if (sel == SEL_EXT)
			r[EXTH_HI:0] = d.ext_identifier[EXT_HI:EXT_SPL];
		else if (sel == SEL_EXTL)
			r[RW-1:EXTL_LO] = d.ext_identifier[EXT_SPL-1:0];
		return r;
	endfunction

	function automatic crb_idr_t idr_write(input crb_idr_t d, input logic [2:0] sel,
		input logic [RW-1:0] v);
		crb_idr_t n;
		n = d;
		if (sel == SEL_STD)
		begin
			n.std_identifier = v[STD_HI:STD_LO];
			n.type_bit       = v[XF_POS];
		end
		else if (sel == SEL_EXT)
			n.ext_identifier[EXT_HI:EXT_SPL] = v[EXTH_HI:0];
		else if (sel == SEL_EXTL)
			n.ext_identifier[EXT_SPL-1:0] = v[RW-1:EXTL_LO];
		return n;
	endfunction

	function automatic logic id_match(input crb_frame_t fr, input crb_idr_t f,
		input crb_idr_t m);
		logic std_ok;
		logic ext_ok;
		logic type_ok;
		std_ok  = ((fr.std_identifier ^ f.std_identifier) & m.std_identifier) == '0;
		ext_ok  = !fr.extended_frame_flag
			|| (((fr.ext_identifier ^ f.ext_identifier) & m.ext_identifier) == '0);
		type_ok = !m.type_bit || (f.type_bit == fr.extended_frame_flag);
		return std_ok && ext_ok && type_ok;
	endfunction

	// ==================================================================
	// Acceptance filtering, lowest filter wins; filters 2n and 2n+1 feed buffer n
	for (genvar f = 0; f < NFLT; f++)
	begin : g_flt
		assign match[f] = id_match(rx_frame, flt_r[f], msk_r[f/2]);
	end

	always_comb
	begin
		win_found = 1'b0;
		win_flt   = '0;
		for (int f = NFLT - 1; f >= 0; f--)
		begin
			if (match[f])
			begin
				win_found = 1'b1;
				win_flt   = 2'(f);
			end
		end
	end

	assign win_buf = win_flt[1];
	assign load    = rx_frame_valid && win_found && !full_r[win_buf] && !pend_r;

	// ==================================================================
	// Bus decode and write steering
	assign dec        = reg_decode(avs_address);
	assign bus_wr     = (st_r == BUS_DONE) && avs_write && dec.hit;
	assign wr16       = avs_writedata[RW-1:0];
	assign be2        = avs_byteenable[1:0];
	assign wsel       = 2'(dec.sel - SEL_DAT0);
	assign is_dat     = (dec.grp == GRP_BUF) && dec.sel >= SEL_DAT0 && dec.sel <= SEL_DAT3;
	assign mem_we_bus = bus_wr && is_dat;
	assign commit     = pend_r && !mem_we_bus;
	assign bus_wbe    = {6'h00, be2} << {wsel, 1'b0};

	crb_mem u_mem (
		.ref_clk (ref_clk),
		.we      (mem_we_bus || commit),
		.waddr   (mem_we_bus ? dec.idx[0] : pend_buf_r),
		.wbe     (mem_we_bus ? bus_wbe : 8'hFF),
		.wdata   (mem_we_bus ? {NWRD{wr16}} : pend_data_r),
		.raddr   (dec.idx[0]),
		.rdata   (mem_rdata)
	);

	// ==================================================================
	// Identifier state, no reset
	always_comb
	begin
		logic [RW-1:0] v;
		v             = '0;
		pend_buf_nxt  = pend_buf_r;
		pend_data_nxt = pend_data_r;
		for (int b = 0; b < NBUF; b++)
		begin
			hdr_nxt[b] = hdr_r[b];
			msk_nxt[b] = msk_r[b];
			if (bus_wr && dec.grp == GRP_BUF && dec.idx[0] == b[0])
			begin
				v = be_merge(buf_read(hdr_r[b], dec.sel), wr16, be2);
				if (dec.sel == SEL_STD)
				begin
					hdr_nxt[b].std_identifier      = v[STD_HI:STD_LO];
					hdr_nxt[b].subst_remote        = v[SUB_POS];
					hdr_nxt[b].extended_frame_flag = v[XF_POS];
				end
				else if (dec.sel == SEL_EXT)
					hdr_nxt[b].ext_identifier[EXT_HI:EXT_SPL] = v[EXTH_HI:0];
				else if (dec.sel == SEL_LEN)
				begin
					hdr_nxt[b].ext_identifier[EXT_SPL-1:0] = v[RW-1:EXTL_LO];
					hdr_nxt[b].remote_request_flag         = v[REM_POS];
					hdr_nxt[b].length_code                 = v[LEN_HI:0];
				end
			end
			if (bus_wr && dec.grp == GRP_MSK && dec.idx[0] == b[0])
				msk_nxt[b] = idr_write(msk_r[b], dec.sel,
					be_merge(idr_read(msk_r[b], dec.sel), wr16, be2));
			if (load && win_buf == b[0])
			begin
				hdr_nxt[b].std_identifier      = rx_frame.std_identifier;
				hdr_nxt[b].ext_identifier      = rx_frame.ext_identifier;
				hdr_nxt[b].extended_frame_flag = rx_frame.extended_frame_flag;
				hdr_nxt[b].subst_remote        = rx_frame.subst_remote;
				hdr_nxt[b].remote_request_flag = rx_frame.remote_request_flag;
				hdr_nxt[b].length_code         = rx_frame.length_code;
				hdr_nxt[b].filter_hit          = {1'b0, win_flt};
			end
		end
		for (int f = 0; f < NFLT; f++)
		begin
			flt_nxt[f] = flt_r[f];
			if (bus_wr && dec.grp == GRP_FLT && dec.idx == 2'(f))
				flt_nxt[f] = idr_write(flt_r[f], dec.sel,
					be_merge(idr_read(flt_r[f], dec.sel), wr16, be2));
		end
		if (load)
		begin
			pend_buf_nxt  = win_buf;
			pend_data_nxt = rx_frame.payload_word;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		hdr_r       <= hdr_nxt;
		flt_r       <= flt_nxt;
		msk_r       <= msk_nxt;
		pend_buf_r  <= pend_buf_nxt;
		pend_data_r <= pend_data_nxt;
	end

	// ==================================================================
	// Full flags and pending payload commit
	always_comb
	begin
		pend_nxt = load ? 1'b1 : (commit ? 1'b0 : pend_r);
		for (int b = 0; b < NBUF; b++)
		begin
			full_nxt[b] = full_r[b];
			if (bus_wr && dec.grp == GRP_BUF && dec.idx[0] == b[0] && dec.sel == SEL_CTL
				&& be2[0] && !wr16[FULL_POS])
				full_nxt[b] = 1'b0;
			if (commit && pend_buf_r == b[0])
				full_nxt[b] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			full_r <= FULL_RST;
			pend_r <= PEND_RST;
		end
		else
		begin
			full_r <= full_nxt;
			pend_r <= pend_nxt;
		end
	end

	// ==================================================================
	// Read mux and bus handshake
	always_comb
	begin
		rd_mux = '0;
		if (dec.hit && dec.grp == GRP_BUF && is_dat)
			rd_mux = mem_rdata[wsel*RW +: RW];
		else if (dec.hit && dec.grp == GRP_BUF)
		begin
			rd_mux = buf_read(hdr_r[dec.idx[0]], dec.sel);
			if (dec.sel == SEL_CTL)
				rd_mux[FULL_POS] = full_r[dec.idx[0]];
		end
		else if (dec.hit && dec.grp == GRP_FLT)
			rd_mux = idr_read(flt_r[dec.idx], dec.sel);
		else if (dec.hit && dec.grp == GRP_MSK)
			rd_mux = idr_read(msk_r[dec.idx[0]], dec.sel);
	end

	always_comb
	begin
		st_nxt    = st_r;
		wait_nxt  = wait_r;
		rdata_nxt = rdata_r;
		unique case (st_r)
			BUS_IDLE:
			begin
				if (avs_read || avs_write)
					st_nxt = BUS_LOOK;
			end
			BUS_LOOK:
			begin
				st_nxt    = BUS_DONE;
				wait_nxt  = 1'b0;
				rdata_nxt = avs_read ? {{(DW-RW){1'b0}}, rd_mux} : RDATA_RST;
			end
			BUS_DONE:
			begin
				st_nxt   = BUS_IDLE;
				wait_nxt = WAIT_RST;
			end
			default:
			begin
				st_nxt   = BUS_IDLE;
				wait_nxt = WAIT_RST;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r    <= BUS_IDLE;
			wait_r  <= WAIT_RST;
			rdata_r <= RDATA_RST;
		end
		else
		begin
			st_r    <= st_nxt;
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_readdata     = rdata_r;
	assign avs_waitrequest  = wait_r;
	assign buffer_full_flag = full_r;

	// ==================================================================
	// Assertions
	logic     rd_look;
	crb_hdr_t pb_hdr;
	crb_hdr_t look_hdr;

	assign rd_look  = (st_r == BUS_LOOK) && avs_read && dec.hit;
	assign pb_hdr   = hdr_r[pend_buf_r];
	assign look_hdr = hdr_r[dec.idx[0]];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_req;
		st_r == BUS_IDLE && (avs_read || avs_write);
	endsequence
	sequence s_ack;
		avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
	endsequence

	AST_BUS_ANSWER:
		assert property (s_req |=> s_ack) else $error("bus answer not on time");
	AST_STD_READ:
		assert property (rd_look && dec.grp == GRP_BUF && dec.sel == SEL_STD
			|=> avs_readdata[DW-1:STD_HI+1] == '0
			&& avs_readdata[STD_HI:STD_LO] == $past(look_hdr.std_identifier))
		else $error("standard id read wrong");
	AST_LOAD_FLAG:
		assert property (load |=> pb_hdr.extended_frame_flag
			== $past(rx_frame.extended_frame_flag)) else $error("frame type not stored");
	AST_LOAD_SUB:
		assert property (load |=> pb_hdr.subst_remote == $past(rx_frame.subst_remote))
		else $error("substitute remote not stored");
	AST_EXT_READ:
		assert property (rd_look && dec.grp == GRP_BUF && dec.sel == SEL_EXT
			|=> avs_readdata[DW-1:EXTH_HI+1] == '0) else $error("extended id upper bits set");
	AST_LOAD_REM:
		assert property (load |=> pb_hdr.remote_request_flag
			== $past(rx_frame.remote_request_flag)) else $error("remote flag not stored");
	AST_LEN_RSV:
		assert property (rd_look && dec.grp == GRP_BUF && dec.sel == SEL_LEN
			|=> !avs_readdata[RSVH_POS] && !avs_readdata[RSVL_POS]
			&& avs_readdata[FULL_POS:RSVL_POS+1] == '0) else $error("reserved bit set");
	AST_LOAD_LEN:
		assert property (load |=> pb_hdr.length_code == $past(rx_frame.length_code))
		else $error("length code not stored");
	AST_FSTD_READ:
		assert property (rd_look && dec.grp == GRP_FLT && dec.sel == SEL_STD
			|=> !avs_readdata[SUB_POS] && avs_readdata[DW-1:STD_HI+1] == '0)
		else $error("filter standard reserved bits set");
	AST_FULL_SET:
		assert property (commit |=> buffer_full_flag[pend_buf_r] && !pend_r)
		else $error("full flag not set on load");
	AST_NO_MATCH:
		assert property (rx_frame_valid && !win_found && !pend_r |=> !pend_r)
		else $error("unmatched frame was taken");

endmodule

`default_nettype wire

// [shared/crb_pkg.sv]
// Register map, field layout and types of the CAN receive buffer and filter block
`default_nettype none

package crb_pkg;

	// ==================================================================
	// Sizes
	localparam int NBUF = 2;
	localparam int NFLT = 4;
	localparam int NWRD = 4;
	localparam int AW   = 8;
	localparam int DW   = 32;
	localparam int RW   = 16;
	localparam int MW   = NWRD * RW;

	// ==================================================================
	// Address map (byte addresses, one 32-bit word per register)
	localparam logic [AW-1:0] BUF_BASE   = 8'h00;
	localparam logic [AW-1:0] BUF_STRIDE = 8'h20;
	localparam logic [AW-1:0] FLT_BASE   = 8'h40;
	localparam logic [AW-1:0] FLT_STRIDE = 8'h10;
	localparam logic [AW-1:0] MSK_BASE   = 8'h80;
	localparam logic [AW-1:0] MSK_STRIDE = 8'h10;
	localparam int            GRP_HI     = 7;
	localparam int            GRP_LO     = 6;
	localparam int            BIDX_POS   = 5;
	localparam int            BSEL_HI    = 4;
	localparam int            FIDX_HI    = 5;
	localparam int            FIDX_LO    = 4;
	localparam int            MIDX_POS   = 4;
	localparam int            FSEL_HI    = 3;
	localparam int            SEL_LO     = 2;
	localparam logic [1:0]    GRP_BUF    = 2'h0;
	localparam logic [1:0]    GRP_FLT    = 2'h1;
	localparam logic [1:0]    GRP_MSK    = 2'h2;

	// Register select within a group
	localparam logic [2:0] SEL_STD  = 3'h0;
	localparam logic [2:0] SEL_EXT  = 3'h1;
	localparam logic [2:0] SEL_LEN  = 3'h2;
	localparam logic [2:0] SEL_EXTL = 3'h2;
	localparam logic [2:0] SEL_HOLE = 3'h3;
	localparam logic [2:0] SEL_DAT0 = 3'h3;
	localparam logic [2:0] SEL_DAT3 = 3'h6;
	localparam logic [2:0] SEL_CTL  = 3'h7;

	// ==================================================================
	// Field positions
	localparam int STD_HI   = 12;
	localparam int STD_LO   = 2;
	localparam int SUB_POS  = 1;
	localparam int XF_POS   = 0;
	localparam int EXTH_HI  = 11;
	localparam int EXT_HI   = 17;
	localparam int EXT_SPL  = 6;
	localparam int EXTL_LO  = 10;
	localparam int REM_POS  = 9;
	localparam int RSVH_POS = 8;
	localparam int RSVL_POS = 4;
	localparam int LEN_HI   = 3;
	localparam int FULL_POS = 7;
	localparam int CREM_POS = 3;
	localparam int HIT_HI   = 2;

	// ==================================================================
	// Reset values
	localparam logic            WAIT_RST  = 1'b1;
	localparam logic [DW-1:0]   RDATA_RST = 32'h0000_0000;
	localparam logic [NBUF-1:0] FULL_RST  = 2'h0;
	localparam logic            PEND_RST  = 1'b0;

	// ==================================================================
	// Types
	typedef struct packed {
		logic [10:0]   std_identifier;
		logic [17:0]   ext_identifier;
		logic          extended_frame_flag;
		logic          subst_remote;
		logic          remote_request_flag;
		logic [3:0]    length_code;
		logic [MW-1:0] payload_word;
	} crb_frame_t;

	typedef struct packed {
		logic [10:0] std_identifier;
		logic [17:0] ext_identifier;
		logic        extended_frame_flag;
		logic        subst_remote;
		logic        remote_request_flag;
		logic [3:0]  length_code;
		logic [2:0]  filter_hit;
	} crb_hdr_t;

	// Filter or mask; type_bit is filter_extended_enable or mask_identifier_mode
	typedef struct packed {
		logic [10:0] std_identifier;
		logic [17:0] ext_identifier;
		logic        type_bit;
	} crb_idr_t;

	typedef struct packed {
		logic       hit;
		logic [1:0] grp;
		logic [1:0] idx;
		logic [2:0] sel;
	} crb_dec_t;

	typedef enum logic [1:0] {BUS_IDLE, BUS_LOOK, BUS_DONE} crb_bus_t;

endpackage

`default_nettype wire

// [logic/crb_mem.sv]
// Payload word store of the receive buffers, byte writable, registered read
`default_nettype none

module crb_mem
	import crb_pkg::*;
(
	// Clock
	input  wire logic            ref_clk,
	// Write port
	input  wire logic            we,
	input  wire logic            waddr,
	input  wire logic [MW/8-1:0] wbe,
	input  wire logic [MW-1:0]   wdata,
	// Read port
	input  wire logic            raddr,
	output logic      [MW-1:0]   rdata
);

	logic [MW-1:0] mem [NBUF];

	// ==================================================================
	// Storage, contents undefined after reset
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < MW / 8; i++)
		begin
			if (we && wbe[i])
				mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
		end
		rdata <= mem[raddr];
	end

endmodule

`default_nettype wire

// [test/crb_node.sv]
// Frame source standing in for the other nodes on the bus
`default_nettype none

module crb_node
	import crb_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Commands from the bench
	input  wire logic       go,
	input  wire crb_frame_t frame_in,
	// Frames towards the receive block
	output var  crb_frame_t rx_frame,
	output var  logic       rx_frame_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================================
	// One frame per command; outside it the frame lines show the inverse of their last value and valid is low
	initial
	begin
		rx_frame = '0;
		rx_frame_valid = 1'b0;
	end

	always @(posedge ref_clk)
	begin
		rx_frame_valid <= go;
		rx_frame <= go ? frame_in : ~rx_frame;
	end
endmodule

`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench of the CAN receive buffer and filter block
`default_nettype none

module testbench
	import crb_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================================
	// Signals
	logic            ref_clk = 1'b0;
	logic            rst = 1'b1;
	logic [AW-1:0]   avs_address = '0;
	logic            avs_read = 1'b0;
	logic            avs_write = 1'b0;
	logic [DW-1:0]   avs_writedata = '0;
	logic [DW/8-1:0] avs_byteenable = '0;
	logic [DW-1:0]   avs_readdata;
	logic            avs_waitrequest;
	crb_frame_t      rx_frame;
	logic            rx_frame_valid;
	logic [NBUF-1:0] buffer_full_flag;
	crb_frame_t      node_frame = '0;
	logic            node_go = 1'b0;
	logic [15:0]     rdv;
	int              bad_count = 0;
	int              n_checks = 0;
	crb_frame_t      fa, fb, fc, fd;

	localparam logic [7:0]  ONES_A [8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
		8'h40, 8'h44, 8'h48, 8'h4C};
	localparam logic [15:0] ONES_E [8] = '{16'h1FFF, 16'h0FFF, 16'hFE0F, 16'hFFFF,
		16'h1FFD, 16'h0FFF, 16'hFC00, 16'h0000};

	initial forever #2 ref_clk = ~ref_clk;

	crb_rx_filter DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_frame(rx_frame),
		.rx_frame_valid(rx_frame_valid), .buffer_full_flag(buffer_full_flag));

	crb_node node (.ref_clk(ref_clk), .go(node_go), .frame_in(node_frame),
		.rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid));

	// ==================================================================
	// Report and compare
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: register %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_full(input logic [NBUF-1:0] exp);
		n_checks++;
		if (buffer_full_flag !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: full flags %b expected %b", $time,
				buffer_full_flag, exp);
		end
	endtask

	// ==================================================================
	// Avalon-MM master
	task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= 4'h3;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		rdv = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0)
		begin
			bad_count++;
			$display("wrong value at %0t: bus answer missing", $time);
			end_of_test();
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000);
		chk_reg(rdv, exp);
	endtask

	// Filter or mask: standard, extended high and extended low registers
	task automatic set_idr(input logic [AW-1:0] b, input logic [10:0] s,
		input logic [17:0] e, input logic t);
		wr(b, {3'h0, s, 1'b0, t});
		wr(b + 8'h04, {4'h0, e[17:6]});
		wr(b + 8'h08, {e[5:0], 10'h000});
	endtask

	// ==================================================================
	// Frames
	function automatic crb_frame_t mk(input logic [10:0] s, input logic [17:0] e,
		input logic [2:0] f, input logic [3:0] dlc, input logic [15:0] p);
		crb_frame_t r;
		r.std_identifier = s;
		r.ext_identifier = e;
		{r.extended_frame_flag, r.subst_remote, r.remote_request_flag} = f;
		r.length_code = dlc;
		r.payload_word = {p + 16'h0003, p + 16'h0002, p + 16'h0001, p};
		return r;
	endfunction

	task automatic send(input crb_frame_t f);
		@(posedge ref_clk);
		node_frame <= f;
		node_go <= 1'b1;
		@(posedge ref_clk);
		node_go <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic chk_buf(input logic [AW-1:0] b, input crb_frame_t f, input logic [2:0] h);
		rd(b, {3'h0, f.std_identifier, f.subst_remote, f.extended_frame_flag});
		rd(b + 8'h04, {4'h0, f.ext_identifier[17:6]});
		rd(b + 8'h08, {f.ext_identifier[5:0], f.remote_request_flag, 5'h00,
			f.length_code});
		for (int m = 0; m < NWRD; m++)
			rd(b + 8'h0C + 8'(4 * m), f.payload_word[16*m +: 16]);
		rd(b + 8'h1C, {8'h00, 1'b1, 3'h0, f.remote_request_flag, h});
	endtask

	// ==================================================================
	// Main sequence
	initial
	begin
		fa = mk(11'h123, 18'h00000, 3'h0, 4'h8, 16'h1100);
		fb = mk(11'h3A5, 18'h2B4C7, 3'h7, 4'h0, 16'h2200);
		fc = mk(11'h2C6, 18'h00000, 3'h0, 4'hF, 16'h3300);
		fd = mk(11'h2C7, 18'h1F0A5, 3'h4, 4'h3, 16'h4400);
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk_full(2'h0);
		for (int i = 0; i < 8; i++)
		begin
			wr(ONES_A[i], 16'hFFFF);
			rd(ONES_A[i], ONES_E[i]);
		end
		set_idr(8'h80, 11'h7FF, 18'h3FFFF, 1'b1);
		set_idr(8'h90, 11'h7FE, 18'h00000, 1'b0);
		rd(8'h80, 16'h1FFD);
		rd(8'h98, 16'h0000);
		set_idr(8'h40, 11'h123, 18'h00000, 1'b0);
		set_idr(8'h50, 11'h3A5, 18'h2B4C7, 1'b1);
		set_idr(8'h60, 11'h2C6, 18'h00000, 1'b1);
		set_idr(8'h70, 11'h000, 18'h00000, 1'b0);
		send(fa);
		chk_full(2'h1);
		chk_buf(8'h00, fa, 3'h0);
		send(fb);
		chk_full(2'h1);
		rd(8'h00, {3'h0, fa.std_identifier, 2'h0});
		wr(8'h1C, 16'h0000);
		rd(8'h1C, 16'h0000);
		send(fb);
		chk_full(2'h1);
		chk_buf(8'h00, fb, 3'h1);
		wr(8'h1C, 16'h0000);
		send(mk(11'h3A5, 18'h00000, 3'h0, 4'h1, 16'h5500));
		send(mk(11'h123, 18'h00000, 3'h4, 4'h1, 16'h6600));
		send(mk(11'h3A5, 18'h2B4C6, 3'h4, 4'h1, 16'h7700));
		chk_full(2'h0);
		send(fc);
		chk_full(2'h2);
		chk_buf(8'h20, fc, 3'h2);
		wr(8'h3C, 16'h0000);
		send(fd);
		chk_full(2'h2);
		chk_buf(8'h20, fd, 3'h2);
		// Reset in mid-run clears the full flags and keeps the stored header
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk_full(2'h0);
		rd(8'h3C, 16'h0002);
		end_of_test();
	end
endmodule

`default_nettype wire
